// ==== core/dom_access_guard.sv ====
// Our own choice: the strobed register port.
`default_nettype none
// Notes on behaviour
// - write bit clear permits, set forbids writes
// - read bit clear permits, set forbids reads
// - 0xb8: domain 5 high, domain 4 low
// - 0xbc: domain 7 high, domain 6 low
// - 0xb4 bit 0: domain 2 master 0 read
// - master 6 bits stored, never checked; gaps unused
// - all authority registers reset to zero
module dom_access_guard
    import dom_access_pkg::*;
(
    input wire logic clk_sys_in,                 // 25 MHz system clock
    input wire logic rst_n_in,                   // async reset, active low
    input wire logic [ADDR_W-1:0] reg_addr_in,   // register byte address
    input wire logic [31:0] reg_wdata_in,        // write data
    input wire logic reg_wr_in,                  // write strobe
    input wire logic reg_rd_in,                  // read strobe
    output logic [31:0] reg_rdata_out,           // read data, cycle after strobe
    input wire access_req_t req_in,              // master access under check
    output access_resp_t resp_out,               // verdict, combinational
    output logic dom2_mst0_read_block_out        // register bit 0 of 0xb4
);
    // ************************************************************
    // authority registers
    // ************************************************************
    logic [31:0] ctrl_d2_d3_reg;  // domains 2/3
    logic [31:0] ctrl_d4_d5_reg;  // domains 4/5
    logic [31:0] ctrl_d6_d7_reg;  // domains 6/7
    logic [31:0] wmasked;         // write data with unused bits dropped

    assign wmasked = reg_wdata_in & CTRL_USED_MASK;

    // domains 2/3 register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_d2_d3_reg <= CTRL_RESET;
        end else if (reg_wr_in && reg_addr_in == OFS_D2_D3) begin
            ctrl_d2_d3_reg <= wmasked;
        end
    end

    // domains 4/5 register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_d4_d5_reg <= CTRL_RESET;
        end else if (reg_wr_in && reg_addr_in == OFS_D4_D5) begin
            ctrl_d4_d5_reg <= wmasked;
        end
    end

    // domains 6/7 register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_d6_d7_reg <= CTRL_RESET;
        end else if (reg_wr_in && reg_addr_in == OFS_D6_D7) begin
            ctrl_d6_d7_reg <= wmasked;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    logic [31:0] rdata_next; // decoded read value

    // unmapped addresses read as zero so software sees a stable value
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_D2_D3: rdata_next = ctrl_d2_d3_reg;
                OFS_D4_D5: rdata_next = ctrl_d4_d5_reg;
                OFS_D6_D7: rdata_next = ctrl_d6_d7_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // read data held only for the cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            reg_rdata_out <= rdata_next;
        end
    end

    assign dom2_mst0_read_block_out = ctrl_d2_d3_reg[0];

    // ************************************************************
    // access checking
    // ************************************************************
    dom_perm_lookup u_lookup (
        .ctrl_d2_d3_in(ctrl_d2_d3_reg),
        .ctrl_d4_d5_in(ctrl_d4_d5_reg),
        .ctrl_d6_d7_in(ctrl_d6_d7_reg),
        .req_in(req_in),
        .resp_out(resp_out)
    );

    // ************************************************************
    // checks
    // ************************************************************
    // one write strobe aimed at each authority register
    sequence s_write_d23;
        reg_wr_in && reg_addr_in == OFS_D2_D3;
    endsequence

    sequence s_write_d45;
        reg_wr_in && reg_addr_in == OFS_D4_D5;
    endsequence

    sequence s_write_d67;
        reg_wr_in && reg_addr_in == OFS_D6_D7;
    endsequence

    // store checks: the masked word shows one edge after the strobe
    // gap bits are dropped on the way in, never stored
    chk_write_d23_store: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_write_d23 |=> ctrl_d2_d3_reg == ($past(reg_wdata_in) & CTRL_USED_MASK))
        else $error("domain 2/3 register did not store write");

    chk_write_d45_store: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_write_d45 |=> ctrl_d4_d5_reg == ($past(reg_wdata_in) & CTRL_USED_MASK))
        else $error("domain 4/5 register did not store write");

    chk_write_d67_store: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        s_write_d67
        |=> ctrl_d6_d7_reg == ($past(reg_wdata_in) & CTRL_USED_MASK))
        else $error("domain 6/7 register did not store write");

    chk_unused_bits_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (ctrl_d2_d3_reg & ~CTRL_USED_MASK) == 32'h0000_0000
        && (ctrl_d4_d5_reg & ~CTRL_USED_MASK) == 32'h0000_0000
        && (ctrl_d6_d7_reg & ~CTRL_USED_MASK) == 32'h0000_0000)
        else $error("unused register bits became set");

    chk_readback_word: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        reg_rd_in && reg_addr_in == OFS_D4_D5 && !reg_wr_in
        |=> reg_rdata_out == $past(ctrl_d4_d5_reg))
        else $error("read data does not match register");

    // readback of the other two registers, same one-cycle timing
    chk_readback_d23: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        reg_rd_in && reg_addr_in == OFS_D2_D3 && !reg_wr_in
        |=> reg_rdata_out == $past(ctrl_d2_d3_reg))
        else $error("read data does not match domain 2/3 register");

    chk_readback_d67: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        reg_rd_in && reg_addr_in == OFS_D6_D7 && !reg_wr_in
        |=> reg_rdata_out == $past(ctrl_d6_d7_reg))
        else $error("read data does not match domain 6/7 register");

    // read data stand one cycle only, then fall back to zero
    chk_rdata_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
        else $error("read data present without a read strobe");

    // without a write strobe a register keeps every bit
    // this also catches a decode that lets one strobe touch two registers
    chk_hold_d23: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !(reg_wr_in && reg_addr_in == OFS_D2_D3) |=> $stable(ctrl_d2_d3_reg))
        else $error("domain 2/3 register changed without a write");

    chk_hold_d45: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !(reg_wr_in && reg_addr_in == OFS_D4_D5) |=> $stable(ctrl_d4_d5_reg))
        else $error("domain 4/5 register changed without a write");

    chk_hold_d67: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !(reg_wr_in && reg_addr_in == OFS_D6_D7) |=> $stable(ctrl_d6_d7_reg))
        else $error("domain 6/7 register changed without a write");

    chk_write_block: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.valid && req_in.write && req_in.domain == 3'h4 && req_in.master == 3'h0
        |-> resp_out.block == ctrl_d4_d5_reg[1])
        else $error("write block does not follow write bit");

    chk_read_block: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.valid && !req_in.write && req_in.domain == 3'h7 && req_in.master == 3'h2
        |-> resp_out.block == ctrl_d6_d7_reg[20])
        else $error("read block does not follow read bit");

    // far ends of the upper and lower half-words
    chk_write_block_hi: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.valid && req_in.write && req_in.domain == 3'h5 && req_in.master == 3'h5
        |-> resp_out.block == ctrl_d4_d5_reg[27])
        else $error("domain 5 write block does not follow its bit");

    chk_read_block_lo: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.valid && !req_in.write && req_in.domain == 3'h6 && req_in.master == 3'h0
        |-> resp_out.block == ctrl_d6_d7_reg[0])
        else $error("domain 6 read block does not follow its bit");

    chk_master6_free: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.valid && req_in.master == 3'h6 |-> resp_out.grant && !resp_out.block)
        else $error("master 6 access was blocked");

    chk_verdict_excl: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.valid |-> (resp_out.grant ^ resp_out.block))
        else $error("verdict neither or both grant and block");

    // no request, no verdict: both halves stay low
    chk_idle_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !req_in.valid |-> !resp_out.grant && !resp_out.block)
        else $error("verdict given without a request");

    // domains 0 and 1 are guarded elsewhere, so they always pass here
    chk_low_dom_open: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.valid && req_in.domain[2:1] == 2'h0 |-> resp_out.grant)
        else $error("access to a domain held elsewhere was blocked");

    chk_dom2_bit0: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        req_in.valid && !req_in.write && req_in.domain == 3'h2 && req_in.master == 3'h0
        |-> resp_out.block == dom2_mst0_read_block_out)
        else $error("domain 2 master 0 read bit misplaced");

    chk_reset_open: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> ctrl_d2_d3_reg == CTRL_RESET
        && ctrl_d4_d5_reg == CTRL_RESET && ctrl_d6_d7_reg == CTRL_RESET)
        else $error("registers not clear after reset");
endmodule // dom_access_guard
`default_nettype wire

// ==== core/dom_access_pkg.sv ====
`default_nettype none
package dom_access_pkg;
    // ************************************************************
    // register map, byte addresses on the plain register port
    // ************************************************************
    localparam int ADDR_W = 8;                          // register port address width
    localparam logic [7:0] OFS_D2_D3 = 8'hb4;           // domains 2 and 3
    localparam logic [7:0] OFS_D4_D5 = 8'hb8;           // domains 4 and 5
    localparam logic [7:0] OFS_D6_D7 = 8'hbc;           // domains 6 and 7
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000; // all permitted
    localparam logic [31:0] CTRL_USED_MASK = 32'h3fff_3fff; // bits 31:30, 15:14 unused

    // ************************************************************
    // field layout of one authority register
    // ************************************************************
    localparam int LO_HALF_BASE = 0;    // even domain base bit
    localparam int HI_HALF_BASE = 16;   // odd domain base bit
    localparam int NUM_MASTERS = 7;     // masters 0..6 have storage
    localparam int NUM_CHECKED = 6;     // master 6 is storage only
    localparam int FIRST_DOMAIN = 2;    // lowest domain held here
    localparam int NUM_DOMAINS = 6;     // domains 2..7
    localparam int DOM_W = 3;           // domain number width
    localparam int MST_W = 3;           // master number width

    // master access request
    typedef struct packed {
        logic valid;            // request present
        logic write;            // 1 write, 0 read
        logic [MST_W-1:0] master;
        logic [DOM_W-1:0] domain;
    } access_req_t;

    // check verdict
    typedef struct packed {
        logic grant;            // access may complete
        logic block;            // access stopped
    } access_resp_t;
endpackage : dom_access_pkg
`default_nettype wire

// ==== core/dom_perm_lookup.sv ====
`default_nettype none
// ************************************************************
// combinational permission lookup for one request
// ************************************************************
module dom_perm_lookup
    import dom_access_pkg::*;
(
    input wire logic [31:0] ctrl_d2_d3_in,   // domains 2/3 bits
    input wire logic [31:0] ctrl_d4_d5_in,   // domains 4/5 bits
    input wire logic [31:0] ctrl_d6_d7_in,   // domains 6/7 bits
    input wire access_req_t req_in,          // request under check
    output access_resp_t resp_out            // verdict
);
    // bit position of the read bit, write bit is one higher
    function automatic logic [4:0] read_pos(input logic [DOM_W-1:0] dom,
                                            input logic [MST_W-1:0] mst);
        logic [4:0] base;
        base = dom[0] ? 5'(HI_HALF_BASE) : 5'(LO_HALF_BASE);
        return 5'(base + 5'({mst, 1'b0}));
    endfunction

    logic [31:0] word;       // register holding the domain
    logic [4:0] pos;         // selected bit position
    logic known;             // domain and master are checked ones
    logic bit_set;           // selected prohibit bit

    // pick register by domain pair, then read or write bit
    always_comb begin
        unique case (req_in.domain[2:1])
            2'h1: word = ctrl_d2_d3_in;
            2'h2: word = ctrl_d4_d5_in;
            2'h3: word = ctrl_d6_d7_in;
            default: word = 32'h0000_0000; // domains 0/1 live elsewhere
        endcase
        pos = 5'(read_pos(req_in.domain, req_in.master) + 5'(req_in.write));
        // master 6 bits are storage only and never block
        known = (req_in.domain[2:1] != 2'h0) && (32'(req_in.master) < NUM_CHECKED);
        bit_set = known && word[pos];
        resp_out.block = req_in.valid && bit_set;
        resp_out.grant = req_in.valid && !bit_set;
    end
endmodule // dom_perm_lookup
`default_nettype wire

// ==== bench/access_master_model.sv ====
`default_nettype none
// *****
// bus master side: one access request held until withdrawn
// *****
module access_master_model
    import dom_access_pkg::*;
(
    input wire logic clk_sys_in, // system clock
    output access_req_t req_out // request toward the guard
);
    timeunit 1ns;
    timeprecision 1ps;
    // start idle so the guard sees no access during reset
    initial req_out = '0;
    // raise a request just after an edge, hold it for a whole cycle
    task automatic issue(input logic wr, input logic [MST_W-1:0] mst,
                         input logic [DOM_W-1:0] dom);
        @(posedge clk_sys_in);
        req_out <= '{valid: 1'b1, write: wr, master: mst, domain: dom};
        @(posedge clk_sys_in);
    endtask
    // withdraw; fields flip so stale values never pass for a live request
    task automatic idle();
        @(posedge clk_sys_in);
        req_out <= '{1'b0, ~req_out.write, ~req_out.master, ~req_out.domain};
    endtask
endmodule // access_master_model
`default_nettype wire

// ==== bench/domain_access_permission_bits_bench.sv ====
`default_nettype none
module domain_access_permission_bits_bench
    import dom_access_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0; // 25 mhz clock
    logic rst_n_in = 1'b0; // reset, active low
    logic [7:0] reg_addr = 8'h00; // register address
    logic [31:0] reg_wdata = 32'h0; // write data
    logic reg_wr = 1'b0; // write strobe
    logic reg_rd = 1'b0; // read strobe
    logic [31:0] reg_rdata; // read data
    logic dom2_mst0_read_block; // copy of bit 0 at 0xb4
    access_req_t req; // request from master model
    access_resp_t resp; // verdict
    int failures = 0; // mismatches
    int n_compared = 0; // comparisons made
    int cycles = 0; // hang guard
    logic [7:0] ofs [3] = '{OFS_D2_D3, OFS_D4_D5, OFS_D6_D7};
    int pos; // bit under test
    logic [2:0] dom; // domain under test
    always #20 clk_sys_in = ~clk_sys_in;
    dom_access_guard u_dom_access_guard (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .req_in(req), .resp_out(resp),
        .dom2_mst0_read_block_out(dom2_mst0_read_block));
    access_master_model u_access_master_model (.clk_sys_in(clk_sys_in), .req_out(req));
    // *****
    // shared tasks
    // *****
    task automatic finish_test();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_expect(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1 check("rdata", reg_rdata, exp);
    endtask
    // verdict is {grant, block}, combinational on the held request
    task automatic verdict(input logic w, input int m, input logic [2:0] d, input logic blk);
        u_access_master_model.issue(w, m[MST_W-1:0], d);
        #1 check("verdict", {30'h0, resp}, {30'h0, ~blk, blk});
    endtask
    // hang guard, far beyond the roughly 900 cycles needed
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end
    // *****
    // main sequence
    // *****
    initial begin
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        foreach (ofs[i]) reg_expect(ofs[i], CTRL_RESET);
        verdict(1'b1, 0, 3'd2, 1'b0);
        verdict(1'b0, 5, 3'd7, 1'b0);
        $display("test reset_state done");
        // one bit at a time: only the matching access stops, and for master 6 none does
        for (int r = 0; r < 3; r++) begin
            for (int h = 0; h < 2; h++) begin
                for (int m = 0; m < NUM_MASTERS; m++) begin
                    for (int w = 0; w < 2; w++) begin
                        pos = h * 16 + 2 * m + w;
                        dom = 3'(FIRST_DOMAIN + 2 * r + h);
                        reg_write(ofs[r], 32'h1 << pos);
                        verdict(w[0], m, dom, m < NUM_CHECKED);
                        verdict(~w[0], m, dom, 1'b0);
                        verdict(w[0], m, dom ^ 3'd1, 1'b0);
                        reg_expect(ofs[r], 32'h1 << pos);
                        if (r == 0) check("d2m0", {31'h0, dom2_mst0_read_block}, {31'h0, pos == 0});
                    end
                end
            end
        end
        $display("test bit_walk done");
        // unused bits drop, unmapped address changes nothing
        foreach (ofs[i]) reg_write(ofs[i], 32'hffff_ffff);
        foreach (ofs[i]) reg_expect(ofs[i], 32'h3fff_3fff);
        reg_write(8'hb0, 32'h0);
        reg_expect(8'hb0, 32'h0);
        reg_expect(OFS_D4_D5, 32'h3fff_3fff);
        verdict(1'b0, 0, 3'd2, 1'b1);
        verdict(1'b1, 0, 3'd1, 1'b0);
        verdict(1'b1, 7, 3'd4, 1'b0);
        $display("test mask_unmapped done");
        // reset in mid-run clears every prohibit bit, so every access is permitted again
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        foreach (ofs[i]) reg_expect(ofs[i], 32'h0);
        verdict(1'b1, 3, 3'd6, 1'b0);
        u_access_master_model.idle();
        #1 check("idle", {30'h0, resp}, 32'h0);
        $display("test mid_reset done");
        finish_test();
    end
endmodule // domain_access_permission_bits_bench
`default_nettype wire
